// [include/timer_pkg.sv]
// Constants, register map and event layout of the four-timer count and reload block.
package timer_pkg;

    localparam int NUM_TIMERS = 4;
    localparam int ADDR_W = 12;
    localparam int IDX_W = 10;
    localparam int DATA_W = 32;
    localparam int COUNT_W = 16;
    localparam int BYTE_W = 8;

    // Register indices; the byte address of a register is four times its index.
    localparam logic [IDX_W-1:0] CNT_LO_IDX [NUM_TIMERS] = '{10'h063, 10'h068, 10'h072, 10'h077};
    localparam logic [IDX_W-1:0] CNT_HI_IDX [NUM_TIMERS] = '{10'h064, 10'h069, 10'h073, 10'h078};
    localparam logic [IDX_W-1:0] CTL_IDX [NUM_TIMERS] = '{10'h080, 10'h081, 10'h082, 10'h083};
    localparam logic [IDX_W-1:0] EVT_IDX [NUM_TIMERS] = '{10'h084, 10'h085, 10'h086, 10'h087};
    localparam logic [IDX_W-1:0] MASK_IDX [NUM_TIMERS] = '{10'h088, 10'h089, 10'h08a, 10'h08b};
    localparam logic [IDX_W-1:0] CMP_IDX [NUM_TIMERS] = '{10'h08c, 10'h08d, 10'h08e, 10'h08f};

    // Control register fields.
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_MODE_BIT = 1;
    localparam int CTL_RLD_BIT = 2;

    // Event, mask register fields.
    localparam int EVT_W = 4;
    localparam int EVT_EOC_BIT = 0;
    localparam int EVT_CAPA_BIT = 1;
    localparam int EVT_CAPB_BIT = 2;
    localparam int EVT_CMP0_BIT = 3;

    // Timers that own capture inputs, and which capture pin feeds each input.
    localparam logic [NUM_TIMERS-1:0] CAPTURE_TIMERS = 4'h a;
    localparam int CAPA_PIN [NUM_TIMERS] = '{0, 0, 0, 2};
    localparam int CAPB_PIN [NUM_TIMERS] = '{0, 1, 0, 3};
    localparam int NUM_CAP_PINS = 4;

    // Reset values.
    localparam logic [COUNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [BYTE_W-1:0] HOLD_RST = 8'h00;
    localparam logic [COUNT_W-1:0] RELOAD_RST = 16'h0000;
    localparam logic [COUNT_W-1:0] CMP_RST = 16'h0000;
    localparam logic [EVT_W-1:0] EVT_RST = 4'h0;
    localparam logic [EVT_W-1:0] MASK_RST = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h00000000;

    typedef enum logic [6:0] {
        KIND_NONE = 7'h01,
        KIND_CNT_LO = 7'h02,
        KIND_CNT_HI = 7'h04,
        KIND_CTL = 7'h08,
        KIND_EVT = 7'h10,
        KIND_MASK = 7'h20,
        KIND_CMP = 7'h40
    } reg_kind_e;

endpackage

// [hdl/timer_count_readout_reload.sv]
// Four 16-bit timers with count readout, reload path and event flags behind an APB slave.
//
// Summary of operation
// - Count low byte reads live count bits 7..0.
// - Count reads never disturb counting or events.
// - Low byte read latches upper count byte.
// - High byte returns the latched upper byte.
// - Count is high byte over low byte.
// - Count and reload bytes share one address.
// - Reload low byte: write-only, reload bits 7..0.
// - Auto-repeat mode reloads at end of count.
// - Force-reload bit loads counter next edge.
// - Terminal-count flag set by end of count.
// - Capture-A flag: capture A or power trip.
// - Capture-B flag set by capture on B.
// - Compare-match-0 flag set on compare match.
// - Reload high byte: write-only, reload bits 15..8.
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps

module timer_count_readout_reload (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [3:0] capture_pin,
    input wire logic [3:0] pwm_power_trip,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq
);

    logic [timer_pkg::COUNT_W-1:0] count_q [timer_pkg::NUM_TIMERS];
    logic [timer_pkg::BYTE_W-1:0] hold_q [timer_pkg::NUM_TIMERS];
    logic [timer_pkg::COUNT_W-1:0] reload_q [timer_pkg::NUM_TIMERS];
    logic [timer_pkg::COUNT_W-1:0] cmp_q [timer_pkg::NUM_TIMERS];
    logic [timer_pkg::EVT_W-1:0] evt_q [timer_pkg::NUM_TIMERS];
    logic [timer_pkg::EVT_W-1:0] mask_q [timer_pkg::NUM_TIMERS];
    logic [timer_pkg::EVT_W-1:0] evt_set [timer_pkg::NUM_TIMERS];
    logic [timer_pkg::NUM_TIMERS-1:0] en_q;
    logic [timer_pkg::NUM_TIMERS-1:0] mode_q;
    logic [timer_pkg::NUM_TIMERS-1:0] load_pend_q;
    logic [timer_pkg::NUM_TIMERS-1:0] eoc;
    logic [timer_pkg::NUM_CAP_PINS-1:0] cap_prev_q;
    logic [timer_pkg::NUM_CAP_PINS-1:0] cap_rise;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic [31:0] rdata;
    timer_pkg::reg_kind_e acc_kind;
    logic [1:0] acc_t;
    logic rd_take;
    logic wr_fire;

    // Which register an address selects; misaligned addresses select nothing.
    function automatic timer_pkg::reg_kind_e reg_kind(input logic [11:0] addr);
        timer_pkg::reg_kind_e k;
        k = timer_pkg::KIND_NONE;
        if (addr[1:0] == 2'h0)
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
            begin
                if (addr[11:2] == timer_pkg::CNT_LO_IDX[t])
                    k = timer_pkg::KIND_CNT_LO;
                if (addr[11:2] == timer_pkg::CNT_HI_IDX[t])
                    k = timer_pkg::KIND_CNT_HI;
                if (addr[11:2] == timer_pkg::CTL_IDX[t])
                    k = timer_pkg::KIND_CTL;
                if (addr[11:2] == timer_pkg::EVT_IDX[t])
                    k = timer_pkg::KIND_EVT;
                if (addr[11:2] == timer_pkg::MASK_IDX[t])
                    k = timer_pkg::KIND_MASK;
                if (addr[11:2] == timer_pkg::CMP_IDX[t])
                    k = timer_pkg::KIND_CMP;
            end
        end
        return k;
    endfunction

    // Which timer an address belongs to.
    function automatic logic [1:0] timer_of(input logic [11:0] addr);
        logic [1:0] n;
        n = 2'h0;
        for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
        begin
            if (addr[11:2] == timer_pkg::CNT_LO_IDX[t] || addr[11:2] == timer_pkg::CNT_HI_IDX[t] ||
                addr[11:2] == timer_pkg::CTL_IDX[t] || addr[11:2] == timer_pkg::EVT_IDX[t] ||
                addr[11:2] == timer_pkg::MASK_IDX[t] || addr[11:2] == timer_pkg::CMP_IDX[t])
                n = 2'(t);
        end
        return n;
    endfunction

    // Byte-lane merge of a 16-bit register.
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
        logic [15:0] r;
        r = old;
        if (st[0])
            r[7:0] = wd[7:0];
        if (st[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction

    assign acc_kind = reg_kind(paddr);
    assign acc_t = timer_of(paddr);
    // The answer is prepared on the first access cycle; the write lands on the completing edge.
    assign rd_take = psel && penable && !pready_q;
    assign wr_fire = psel && penable && pready_q && pwrite && (acc_kind != timer_pkg::KIND_NONE);

    // Read multiplexer; count addresses return count data, never reload data.
    always_comb
    begin
        rdata = 32'h00000000;
        unique case (acc_kind)
            timer_pkg::KIND_CNT_LO:
                rdata[7:0] = count_q[acc_t][7:0];
            timer_pkg::KIND_CNT_HI:
                rdata[7:0] = hold_q[acc_t];
            timer_pkg::KIND_CTL:
            begin
                rdata[timer_pkg::CTL_EN_BIT] = en_q[acc_t];
                rdata[timer_pkg::CTL_MODE_BIT] = mode_q[acc_t];
            end
            timer_pkg::KIND_EVT:
                rdata[timer_pkg::EVT_W-1:0] = evt_q[acc_t];
            timer_pkg::KIND_MASK:
                rdata[timer_pkg::EVT_W-1:0] = mask_q[acc_t];
            timer_pkg::KIND_CMP:
                rdata[15:0] = cmp_q[acc_t];
            timer_pkg::KIND_NONE:
                rdata = 32'h00000000;
        endcase
    end

    // APB answer: one wait state, error on unmapped or misaligned addresses.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= timer_pkg::RDATA_RST;
        end
        else if (rd_take)
        begin
            pready_q <= 1'b1;
            pslverr_q <= (acc_kind == timer_pkg::KIND_NONE);
            prdata_q <= pwrite ? 32'h00000000 : rdata;
        end
        else
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Upper count byte held at the same edge that captures the low byte for the bus.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
                hold_q[t] <= timer_pkg::HOLD_RST;
        end
        else if (rd_take && !pwrite && acc_kind == timer_pkg::KIND_CNT_LO)
            hold_q[acc_t] <= count_q[acc_t][15:8];
    end

    // Reload value; each byte is taken only by a write to its own address.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
                reload_q[t] <= timer_pkg::RELOAD_RST;
        end
        else if (wr_fire && pstrb[0])
        begin
            if (acc_kind == timer_pkg::KIND_CNT_LO)
                reload_q[acc_t][7:0] <= pwdata[7:0];
            if (acc_kind == timer_pkg::KIND_CNT_HI)
                reload_q[acc_t][15:8] <= pwdata[7:0];
        end
    end

    // Compare value.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
                cmp_q[t] <= timer_pkg::CMP_RST;
        end
        else if (wr_fire && acc_kind == timer_pkg::KIND_CMP)
            cmp_q[acc_t] <= merge16(cmp_q[acc_t], pwdata, pstrb);
    end

    // Control: enable and mode; a one-shot timer stops itself at end of count.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            en_q <= 4'h0;
            mode_q <= 4'h0;
            load_pend_q <= 4'h0;
        end
        else
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
            begin
                if (wr_fire && pstrb[0] && acc_kind == timer_pkg::KIND_CTL && acc_t == 2'(t))
                begin
                    en_q[t] <= pwdata[timer_pkg::CTL_EN_BIT];
                    mode_q[t] <= pwdata[timer_pkg::CTL_MODE_BIT];
                    load_pend_q[t] <= pwdata[timer_pkg::CTL_RLD_BIT];
                end
                else
                begin
                    load_pend_q[t] <= 1'b0;
                    if (eoc[t] && !mode_q[t])
                        en_q[t] <= 1'b0;
                end
            end
        end
    end

    // End of count is a running timer sitting at zero with no forced load pending.
    always_comb
    begin
        for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
            eoc[t] = en_q[t] && !load_pend_q[t] && (count_q[t] == 16'h0000);
    end

    // Down counter; bus reads do not appear here at all.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
                count_q[t] <= timer_pkg::COUNT_RST;
        end
        else
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
            begin
                if (load_pend_q[t])
                    count_q[t] <= reload_q[t];
                else if (eoc[t])
                begin
                    if (mode_q[t])
                        count_q[t] <= reload_q[t];
                end
                else if (en_q[t])
                    count_q[t] <= count_q[t] - 16'h0001;
            end
        end
    end

    // Capture pins are sampled to find rising edges.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cap_prev_q <= 4'h0;
        else
            cap_prev_q <= capture_pin;
    end

    assign cap_rise = capture_pin & ~cap_prev_q;

    always_comb
    begin
        for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
        begin
            evt_set[t] = 4'h0;
            evt_set[t][timer_pkg::EVT_EOC_BIT] = eoc[t];
            evt_set[t][timer_pkg::EVT_CAPA_BIT] = timer_pkg::CAPTURE_TIMERS[t] &&
                (cap_rise[timer_pkg::CAPA_PIN[t]] || pwm_power_trip[t]);
            evt_set[t][timer_pkg::EVT_CAPB_BIT] = timer_pkg::CAPTURE_TIMERS[t] &&
                cap_rise[timer_pkg::CAPB_PIN[t]];
            evt_set[t][timer_pkg::EVT_CMP0_BIT] = en_q[t] && (count_q[t] == cmp_q[t]);
        end
    end

    // Sticky event flags, write one to clear; a new event in the clearing cycle wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
                evt_q[t] <= timer_pkg::EVT_RST;
        end
        else
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
            begin
                if (wr_fire && pstrb[0] && acc_kind == timer_pkg::KIND_EVT && acc_t == 2'(t))
                    evt_q[t] <= (evt_q[t] & ~pwdata[timer_pkg::EVT_W-1:0]) | evt_set[t];
                else
                    evt_q[t] <= evt_q[t] | evt_set[t];
            end
        end
    end

    // Interrupt masks.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
                mask_q[t] <= timer_pkg::MASK_RST;
        end
        else if (wr_fire && pstrb[0] && acc_kind == timer_pkg::KIND_MASK)
            mask_q[acc_t] <= pwdata[timer_pkg::EVT_W-1:0];
    end

    // Level interrupt, registered so it lags the flags by one cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_q <= 1'b0;
        else
        begin
            irq_q <= 1'b0;
            for (int t = 0; t < timer_pkg::NUM_TIMERS; t++)
            begin
                if (|(evt_q[t] & mask_q[t]))
                    irq_q <= 1'b1;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

endmodule

// [tb/timer_chk.sv]
// Bus timing and response checks on the pins of the four-timer register block.
`timescale 1ns/100ps
module timer_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [3:0] capture_pin,
    input wire logic [3:0] pwm_power_trip,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable && !pready;

    one_wait_a: assert property (acc |=> pready)
        else $error("No answer one cycle after the access phase began.");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("Ready stood longer than one cycle.");
    ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
        else $error("Ready without an access phase.");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("Error flag without ready.");
    misalign_err_a: assert property (acc && !pwrite && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0)
        else $error("Misaligned read not refused.");
    count_addr_ok_a: assert property (acc && paddr == 12'h18c |=> !pslverr)
        else $error("Count address refused.");
    write_rdata_a: assert property (acc && pwrite |=> prdata == 32'h0)
        else $error("Write returned read data.");
    byte_read_a: assert property (acc && !pwrite && paddr[11:4] == 8'h18 |=> prdata[31:8] == 24'h0)
        else $error("Count byte read has upper bits set.");
    reset_quiet_a: assert property ($rose(presetn) |-> !irq && !pready)
        else $error("Outputs active right after reset.");
endmodule

bind timer_count_readout_reload timer_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .capture_pin(capture_pin),
    .pwm_power_trip(pwm_power_trip), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// [tb/apb_host.sv]
// Processor-side bus master model that issues register transfers to the timer block.
`timescale 1ns/100ps
module apb_host (
    input wire logic pclk,
    input wire logic pready,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
    end

    // Called just after a rising edge; released lines are inverted so stale values never look valid.
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask
endmodule

// [tb/timer_count_readout_reload_test.sv]
// Self-checking testbench for the four-timer count readout and reload block.
`timescale 1ns/100ps
module timer_count_readout_reload_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] capture_pin, pwm_power_trip, pstrb;
    // Each note holds the expected error flag above the expected read data.
    logic [32:0] exp_q[$];
    logic [32:0] e_cur;
    logic [15:0] rl;
    int failures = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [1:0] ct[9] = '{2'h1, 2'h1, 2'h3, 2'h3, 2'h1, 2'h3, 2'h1, 2'h0, 2'h2};
    logic [3:0] cp[9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0, 4'hc, 4'hf, 4'hf};
    logic [3:0] cw[9] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h8, 4'h0, 4'hf, 4'hf};
    logic [3:0] ce[9] = '{4'h2, 4'h4, 4'h2, 4'h4, 4'h2, 4'h2, 4'h0, 4'h0, 4'h0};

    timer_count_readout_reload uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .capture_pin(capture_pin),
        .pwm_power_trip(pwm_power_trip), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
    apb_host host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] d);
        host.xfer({idx, 2'b00}, 1'b1, d);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] e);
        exp_q.push_back({1'b0, e});
        host.xfer({idx, 2'b00}, 1'b0, 32'h0);
    endtask

    task automatic irq_is(input logic e);
        @(posedge pclk);
        #1;
        check({31'h0, irq}, {31'h0, e});
    endtask

    // Read results are matched in completion order against the notes left by the driver.
    always @(posedge pclk)
    begin
        cycles++;
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            e_cur = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1deadbeef;
            check(prdata, e_cur[31:0]);
            check({31'h0, pslverr}, {31'h0, e_cur[32]});
        end
        if (cycles == 5000)
        begin
            failures++;
            test_done();
        end
    end

    initial
    begin
        presetn = 1'b0;
        pstrb = 4'hf;
        capture_pin = 4'h0;
        pwm_power_trip = 4'h0;
        void'($urandom(41155));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int t = 0; t < 4; t++)
        begin
            rd(timer_pkg::CNT_LO_IDX[t], 32'h0);
            rd(timer_pkg::CNT_HI_IDX[t], 32'h0);
            rd(timer_pkg::EVT_IDX[t], 32'h0);
        end
        exp_q.push_back({1'b1, 32'h0});
        host.xfer(12'h000, 1'b0, 32'h0);
        exp_q.push_back({1'b1, 32'h0});
        host.xfer(12'h18d, 1'b0, 32'h0);
        $display("Reset values and refusals done");
        for (int t = 0; t < 4; t++)
        begin
            rl = 16'($urandom);
            wr(timer_pkg::CNT_LO_IDX[t], {24'h0, rl[7:0]});
            wr(timer_pkg::CNT_HI_IDX[t], {24'h0, rl[15:8]});
            wr(timer_pkg::CTL_IDX[t], 32'h4);
            rd(timer_pkg::CNT_LO_IDX[t], {24'h0, rl[7:0]});
            rd(timer_pkg::CNT_HI_IDX[t], {24'h0, rl[15:8]});
            wr(timer_pkg::CNT_HI_IDX[t], {24'h0, ~rl[15:8]});
            wr(timer_pkg::CTL_IDX[t], 32'h4);
            rd(timer_pkg::CNT_HI_IDX[t], {24'h0, rl[15:8]});
            rd(timer_pkg::CNT_LO_IDX[t], {24'h0, rl[7:0]});
            rd(timer_pkg::CNT_HI_IDX[t], {24'h0, ~rl[15:8]});
        end
        // A count-low write without its byte strobe must leave the reload value alone.
        pstrb <= 4'h0;
        wr(timer_pkg::CNT_LO_IDX[3], {24'h0, ~rl[7:0]});
        pstrb <= 4'hf;
        wr(timer_pkg::CTL_IDX[3], 32'h4);
        rd(timer_pkg::CNT_LO_IDX[3], {24'h0, rl[7:0]});
        $display("Reload and hold path done");
        for (int t = 0; t < 4; t += 2)
        begin
            wr(timer_pkg::CNT_LO_IDX[t], 32'h6);
            wr(timer_pkg::CNT_HI_IDX[t], 32'h0);
            wr(timer_pkg::CMP_IDX[t], 32'h2);
            wr(timer_pkg::CTL_IDX[t], t == 0 ? 32'h5 : 32'h7);
            repeat (8) @(posedge pclk);
            rd(timer_pkg::EVT_IDX[t], 32'h9);
            rd(timer_pkg::CTL_IDX[t], t == 0 ? 32'h0 : 32'h3);
        end
        // Stop the free-running timer and clear its flags so later flag reads start clean.
        wr(timer_pkg::CTL_IDX[2], 32'h0);
        wr(timer_pkg::EVT_IDX[2], 32'hf);
        rd(timer_pkg::CNT_LO_IDX[0], 32'h0);
        $display("Counting modes done");
        wr(timer_pkg::MASK_IDX[0], 32'h1);
        irq_is(1'b1);
        wr(timer_pkg::MASK_IDX[0], 32'h0);
        irq_is(1'b0);
        wr(timer_pkg::MASK_IDX[0], 32'h1);
        irq_is(1'b1);
        wr(timer_pkg::EVT_IDX[0], 32'hf);
        irq_is(1'b0);
        rd(timer_pkg::EVT_IDX[0], 32'h0);
        $display("Interrupt done");
        for (int i = 0; i < 9; i++)
        begin
            capture_pin <= cp[i];
            pwm_power_trip <= cw[i];
            repeat (2) @(posedge pclk);
            capture_pin <= 4'h0;
            pwm_power_trip <= 4'h0;
            repeat (2) @(posedge pclk);
            rd(timer_pkg::EVT_IDX[ct[i]], {28'h0, ce[i]});
            wr(timer_pkg::EVT_IDX[ct[i]], 32'hf);
        end
        $display("Capture flags done");
        test_done();
    end
endmodule
